/* verilog/dpr_pkg.sv */
// Package: constants and carrier types for the pattern readout block.
// Assumes a single command clock; commands arrive already decoded to pins.
package dpr_pkg;
   localparam int          DPR_BEATS        = 8;
   localparam int          DPR_LANE_W       = 8;
   localparam int          DPR_ADDR_W       = 16;
   localparam int          DPR_BA_W         = 3;
   // Address bit positions
   localparam int          DPR_A_CHOP       = 12;
   localparam int          DPR_A_AP         = 10;
   localparam int          DPR_A_NIBBLE     = 2;
   localparam int          DPR_A_PAT_EN     = 2;
   localparam int          DPR_A_DLL_OFF    = 0;
   localparam int          DPR_A_LOC_LO     = 0;
   localparam int          DPR_A_BL_LO      = 0;
   // Mode register select codes on the bank address
   localparam logic [2:0]  DPR_MR_BURST     = 3'h0;
   localparam logic [2:0]  DPR_MR_DLL       = 3'h1;
   localparam logic [2:0]  DPR_MR_PATTERN   = 3'h3;
   // Burst length field values
   localparam logic [1:0]  DPR_BL_FIXED8    = 2'h0;
   localparam logic [1:0]  DPR_BL_OTF       = 2'h1;
   localparam logic [1:0]  DPR_BL_FIXED4    = 2'h2;
   // Calibration pattern, beat 0 in bit 0
   localparam logic [7:0]  DPR_CAL_PATTERN  = 8'haa;
   localparam logic [1:0]  DPR_LOC_CAL      = 2'h0;
   // Reset values and DLL-off latency settings
   localparam logic [3:0]  DPR_RST_RL       = 4'h6;
   localparam logic [3:0]  DPR_RST_AL       = 4'h0;
   localparam logic [3:0]  DPR_RST_WL       = 4'h6;
   localparam logic [3:0]  DPR_DLL_OFF_RL   = 4'h6;
   localparam logic [3:0]  DPR_DLL_OFF_WL   = 4'h6;
   localparam logic [4:0]  DPR_DLL_OFF_SHIFT = 5'h1;

   typedef struct packed {
      logic                  cs_n;
      logic                  ras_n;
      logic                  cas_n;
      logic                  we_n;
      logic [DPR_BA_W-1:0]   ba;
      logic [DPR_ADDR_W-1:0] addr;
   } dpr_cmd_t;

   typedef struct packed {
      logic                  valid;
      logic                  pattern;
      logic [7:0]            beats;
      logic [2:0]            count;
   } dpr_burst_t;

   typedef struct packed {
      logic [3:0]            read_lat;
      logic [3:0]            add_lat;
      logic [3:0]            write_lat;
      logic [1:0]            burst_len;
      logic [1:0]            location;
      logic                  pattern_en;
      logic                  dll_off;
   } dpr_mode_t;
endpackage : dpr_pkg

/* verilog/dpr_delay.sv */
// Delay line: holds a read request for a programmable number of cycles.
// Assumes requests no closer than the burst length in cycles.
`timescale 1ns/10ps
`default_nettype none
module dpr_delay #(
   parameter int DEPTH = 32,
   parameter int W     = 12
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [W-1:0]     data_in,
   input  wire logic             valid_in,
   input  wire logic [4:0]       delay_in,
   output var  logic [W-1:0]     data_out,
   output var  logic             valid_out
);
   logic [W-1:0] data_q  [DEPTH];
   logic         valid_q [DEPTH];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_stage
         // Head stage split off so stage 0 never names index minus one
         if (g == 0) begin : g_head
            always_ff @(posedge clk_in or negedge rst_n_in) begin
               if (!rst_n_in) begin
                  data_q[g]  <= '0;
                  valid_q[g] <= 1'b0;
               end else begin
                  data_q[g]  <= data_in;
                  valid_q[g] <= valid_in;
               end
            end
         end else begin : g_tail
            always_ff @(posedge clk_in or negedge rst_n_in) begin
               if (!rst_n_in) begin
                  data_q[g]  <= '0;
                  valid_q[g] <= 1'b0;
               end else begin
                  data_q[g]  <= data_q[g-1];
                  valid_q[g] <= valid_q[g-1];
               end
            end
         end
      end
   endgenerate

   // Tap one stage earlier than delay: stage 0 already costs a cycle
   always_comb begin
      if (delay_in == 5'h0) begin
         data_out  = data_in;
         valid_out = valid_in;
      end else begin
         data_out  = data_q[delay_in - 5'h1];
         valid_out = valid_q[delay_in - 5'h1];
      end
   end
endmodule // dpr_delay
`default_nettype wire

/* verilog/dpr_readout.sv */
// Command-side logic: mode registers, pattern reads, read latency.
// Assumes command pins already synchronous to MCLK_IN (memory clock).
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Pattern sent as one bit on all pins
// - Bit0 of both lanes carries; others copy
// - Bank, column 9-3, precharge, bit11 ignored
// - Eight-beat burst returns beats 0 to 7
// - Chopped burst: bit2 picks low/high nibble
// - Chop fixed or per command if enabled
// - Pattern reads use normal read latency
// - Beat 0 is LSB, beat 7 MSB
// - Location 00 gives 0101 pattern; others reserved
// - No-operation starts nothing, work continues
// - Deselect executes nothing, work continues
// - DLL register bit0 set disables DLL
// - DLL bit accepted only at a DLL register write
// - DLL off supports read/write latency six
// - DLL off: data one cycle earlier
// - Pattern mode bit2 redirects all reads
module dpr_readout
   import dpr_pkg::*;
#(
   parameter int MAX_LAT = 32
) (
   input  wire logic                     MCLK_IN,
   input  wire logic                     RESETN_IN,
   input  wire dpr_pkg::dpr_cmd_t        CMD_IN,
   input  wire logic [2*DPR_LANE_W-1:0]  ARRAY_DATA_IN,
   input  wire logic                     COPY_BIT_IN,
   output var  logic [2*DPR_LANE_W-1:0]  DQ_OUT,
   output var  logic                     DQ_OE_OUT,
   output var  logic                     ARRAY_READ_OUT,
   output var  logic                     DLL_OFF_OUT,
   output var  logic                     PATTERN_MODE_OUT,
   output var  logic                     LAT_SUPPORTED_OUT
);
   import dpr_pkg::*;

   dpr_mode_t  mode_q;
   dpr_burst_t burst_q;
   logic       cmd_sel;
   logic       is_mrs;
   logic       is_read;
   logic       chop;
   logic [4:0] latency;
   logic [11:0] req_d;
   logic [11:0] req_out;
   logic       req_valid;
   logic       copy_beat;
   logic [DPR_LANE_W-1:0] lane_q [2];

   // Deselect and no-operation decode to nothing; burst keeps running
   assign cmd_sel = !CMD_IN.cs_n;

   // Strobe decode; every other command code is dropped here
   always_comb begin
      is_mrs  = 1'b0;
      is_read = 1'b0;
      if (cmd_sel) begin
         case ({CMD_IN.ras_n, CMD_IN.cas_n, CMD_IN.we_n})
            3'h0: begin
               is_mrs = 1'b1;
            end
            3'h5: begin
               is_read = 1'b1;
            end
            default: begin
               is_mrs  = 1'b0;
               is_read = 1'b0;
            end
         endcase
      end
   end

   // Mode register writes, accepted any time after reset
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         mode_q.read_lat   <= DPR_RST_RL;
         mode_q.add_lat    <= DPR_RST_AL;
         mode_q.write_lat  <= DPR_RST_WL;
         mode_q.burst_len  <= DPR_BL_FIXED8;
         mode_q.location   <= DPR_LOC_CAL;
         mode_q.pattern_en <= 1'b0;
         mode_q.dll_off    <= 1'b0;
      end else if (is_mrs) begin
         case (CMD_IN.ba)
            DPR_MR_BURST: begin
               mode_q.burst_len <= CMD_IN.addr[DPR_A_BL_LO +: 2];
               mode_q.read_lat  <= CMD_IN.addr[7:4];
            end
            DPR_MR_DLL: begin
               mode_q.dll_off <= CMD_IN.addr[DPR_A_DLL_OFF];
               mode_q.add_lat <= {2'h0, CMD_IN.addr[4:3]};
            end
            3'h2: begin
               mode_q.write_lat <= CMD_IN.addr[6:3] + 4'h5;
            end
            DPR_MR_PATTERN: begin
               mode_q.pattern_en <= CMD_IN.addr[DPR_A_PAT_EN];
               mode_q.location   <= CMD_IN.addr[DPR_A_LOC_LO +: 2];
            end
            default: begin
               mode_q.dll_off <= mode_q.dll_off;
            end
         endcase
      end
   end

   // Only the documented pairing is guaranteed with DLL off
   assign LAT_SUPPORTED_OUT = !mode_q.dll_off
      || (mode_q.read_lat == DPR_DLL_OFF_RL
          && mode_q.write_lat == DPR_DLL_OFF_WL);

   // Fixed chop, or per command when on-the-fly enabled
   always_comb begin
      case (mode_q.burst_len)
         DPR_BL_FIXED4: chop = 1'b1;
         DPR_BL_OTF:    chop = !CMD_IN.addr[DPR_A_CHOP];
         default:       chop = 1'b0;
      endcase
   end

   // Request word: pattern flag, chop, nibble; other address ignored
   assign req_d = {mode_q.pattern_en, chop,
                   CMD_IN.addr[DPR_A_NIBBLE], 9'h0};

   // Same latency path for array and pattern reads
   // A shallow delay line must never be tapped past its last stage
   always_comb begin
      latency = 5'(mode_q.read_lat) + 5'(mode_q.add_lat);
      if (mode_q.dll_off && latency != 5'h0) begin
         latency = latency - DPR_DLL_OFF_SHIFT;
      end
      if (latency > 5'(MAX_LAT - 1)) begin
         latency = 5'(MAX_LAT - 1);
      end
   end

   dpr_delay #(
      .DEPTH (MAX_LAT),
      .W     (12)
   ) u_delay (
      .clk_in    (MCLK_IN),
      .rst_n_in  (RESETN_IN),
      .data_in   (req_d),
      .valid_in  (is_read),
      .delay_in  (latency),
      .data_out  (req_out),
      .valid_out (req_valid)
   );

   // Array fetch only outside pattern mode
   assign ARRAY_READ_OUT = is_read && !mode_q.pattern_en;
   assign DLL_OFF_OUT      = mode_q.dll_off;
   assign PATTERN_MODE_OUT = mode_q.pattern_en;

   // Burst sequencer: one beat a cycle, one-bit stream
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         burst_q <= '0;
      end else if (req_valid) begin
         burst_q.valid   <= 1'b1;
         burst_q.pattern <= req_out[11];
         // Reserved locations read the same pattern here
         if (req_out[10]) begin
            burst_q.beats <= req_out[9] ? {4'h0, DPR_CAL_PATTERN[7:4]}
                                        : {4'h0, DPR_CAL_PATTERN[3:0]};
            burst_q.count <= 3'h3;
         end else begin
            burst_q.beats <= DPR_CAL_PATTERN;
            burst_q.count <= 3'h7;
         end
      end else if (burst_q.valid) begin
         burst_q.beats <= {1'b0, burst_q.beats[7:1]};
         burst_q.count <= burst_q.count - 3'h1;
         if (burst_q.count == 3'h0) begin
            burst_q.valid <= 1'b0;
         end
      end
   end

   // Strobe window follows the sequencer by one register
   always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         DQ_OE_OUT <= 1'b0;
      end else begin
         DQ_OE_OUT <= burst_q.valid;
      end
   end

   // Zero fill keeps upper bits quiet when copying is off
   assign copy_beat = COPY_BIT_IN & burst_q.beats[0];

   // Data pins registered per lane; bit 0 carries the beat in pattern reads
   genvar lane;
   generate
      for (lane = 0; lane < 2; lane++) begin : g_lane
         always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
            if (!RESETN_IN) begin
               lane_q[lane] <= '0;
            end else if (burst_q.valid && burst_q.pattern) begin
               lane_q[lane] <= {{(DPR_LANE_W - 1){copy_beat}},
                                burst_q.beats[0]};
            end else if (burst_q.valid) begin
               // Array data passes unchanged on both lanes
               lane_q[lane] <= ARRAY_DATA_IN[lane*DPR_LANE_W +: DPR_LANE_W];
            end else begin
               lane_q[lane] <= '0;
            end
         end
      end
   endgenerate

   assign DQ_OUT = {lane_q[1], lane_q[0]};
endmodule // dpr_readout
`default_nettype wire

/* dv/dpr_assertions.sv */
// Checker: port-level properties of the pattern readout block.
// Assumes reads spaced past their burst and RL 6, AL 0 when reading.
`timescale 1ns/10ps
`default_nettype none
module dpr_assertions
   import dpr_pkg::*;
#(
   parameter int MAX_LAT = 32
) (
   input wire logic              MCLK_IN,
   input wire logic              RESETN_IN,
   input wire dpr_pkg::dpr_cmd_t CMD_IN,
   input wire logic [15:0]       ARRAY_DATA_IN,
   input wire logic              COPY_BIT_IN,
   input wire logic [15:0]       DQ_OUT,
   input wire logic              DQ_OE_OUT,
   input wire logic              ARRAY_READ_OUT,
   input wire logic              DLL_OFF_OUT,
   input wire logic              PATTERN_MODE_OUT,
   input wire logic              LAT_SUPPORTED_OUT
);
   logic rd, mrs, oe, pm;
   assign rd = !CMD_IN.cs_n && CMD_IN.ras_n && !CMD_IN.cas_n && CMD_IN.we_n;
   assign mrs = !(CMD_IN.cs_n | CMD_IN.ras_n | CMD_IN.cas_n | CMD_IN.we_n);
   assign oe = DQ_OE_OUT;
   assign pm = PATTERN_MODE_OUT;
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RESETN_IN);
   a_lat_dll_on: assert property (rd && !DLL_OFF_OUT && !oe |->
      !oe[*8] ##1 oe) else $error("read data not at eight");
   a_lat_dll_off: assert property (rd && DLL_OFF_OUT && !oe |->
      !oe[*7] ##1 oe) else $error("read data not at seven");
   a_lane_fill: assert property (oe && pm |-> DQ_OUT ==
      (COPY_BIT_IN ? {16{DQ_OUT[0]}} : {7'h0, DQ_OUT[0], 7'h0, DQ_OUT[0]}))
      else $error("lane bits wrong");
   a_first_beat: assert property ($rose(oe) && pm |->
      !DQ_OUT[0]) else $error("beat zero not low");
   a_beat_toggle: assert property (oe && $past(oe) && pm |->
      DQ_OUT[0] != $past(DQ_OUT[0])) else $error("pattern not alternating");
   a_no_array: assert property (rd && pm |->
      !ARRAY_READ_OUT) else $error("array read in pattern mode");
   a_array_fetch: assert property (rd && !pm |->
      ARRAY_READ_OUT) else $error("array read missing");
   a_mode_hold: assert property (!mrs |=> $stable(DLL_OFF_OUT) &&
      $stable(pm)) else $error("mode changed without write");
   a_dll_write: assert property (mrs && CMD_IN.ba == DPR_MR_DLL |=>
      DLL_OFF_OUT == $past(CMD_IN.addr[0])) else $error("dll bit lost");
   c_pat_read: cover property (rd && pm);
   c_off_read: cover property (rd && DLL_OFF_OUT);
   c_burst_end: cover property ($fell(oe));
endmodule // dpr_assertions
bind dpr_readout dpr_assertions #(.MAX_LAT(MAX_LAT)) u_dpr_assertions (
   .MCLK_IN, .RESETN_IN, .CMD_IN, .ARRAY_DATA_IN, .COPY_BIT_IN, .DQ_OUT,
   .DQ_OE_OUT, .ARRAY_READ_OUT, .DLL_OFF_OUT, .PATTERN_MODE_OUT,
   .LAT_SUPPORTED_OUT);
`default_nettype wire

/* dv/dpr_ctrl_model.sv */
// Partner: memory controller driving the command pins.
// Assumes the caller spaces reads past each burst.
`timescale 1ns/10ps
`default_nettype none
module dpr_ctrl_model
   import dpr_pkg::*;
(
   input  wire logic          clk_in,
   output var  dpr_pkg::dpr_cmd_t cmd_out
);
   initial cmd_out = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h5, 16'ha5a5};
   task automatic issue(input logic [3:0] p, input logic [2:0] ba,
         input logic [15:0] a, input dpr_cmd_t fill);
      @(posedge clk_in);
      cmd_out <= '{p[3], p[2], p[1], p[0], ba, a};
      @(posedge clk_in);
      cmd_out <= fill;
   endtask
   // Caller keeps banks idle, and RL/WL 6 before each DLL register write
   task automatic mrs(input logic [2:0] ba, input logic [15:0] a,
         input dpr_cmd_t fill);
      issue(4'h0, ba, a, fill);
   endtask
   // No lock wait modelled: the block has no lock time of its own
   task automatic rd(input logic [15:0] a, input dpr_cmd_t fill);
      issue(4'h5, 3'h7, {a[15:2], 2'h0}, fill);
   endtask
endmodule // dpr_ctrl_model
`default_nettype wire

/* dv/ddr3_pattern_readout_dll_off_tb_top.sv */
// Testbench: pattern reads, chop, no-op, deselect, DLL-off latency.
// Assumes reset values RL 6, AL 0, WL 6, fixed eight-beat bursts.
`timescale 1ns/10ps
`default_nettype none
module ddr3_pattern_readout_dll_off_tb_top;
   import dpr_pkg::*;
   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic [15:0] arr = 16'h5a3c;
   logic        copy = 1'b1;
   dpr_cmd_t    cmd;
   logic [15:0] dq;
   logic        oe, ard, dll, pat, lat_ok;
   int          fails = 0;
   int          checked = 0;
   localparam dpr_cmd_t nop_c = '{1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 16'h0};
   localparam dpr_cmd_t dsel_c = '{1'b1, 1'b1, 1'b0, 1'b1, 3'h2, 16'h0};
   always #50 mclk = ~mclk;
   dpr_readout u_dpr_readout (.MCLK_IN(mclk), .RESETN_IN(rstn), .CMD_IN(cmd),
      .ARRAY_DATA_IN(arr), .COPY_BIT_IN(copy), .DQ_OUT(dq), .DQ_OE_OUT(oe),
      .ARRAY_READ_OUT(ard), .DLL_OFF_OUT(dll), .PATTERN_MODE_OUT(pat),
      .LAT_SUPPORTED_OUT(lat_ok));
   dpr_ctrl_model u_dpr_ctrl_model (.clk_in(mclk), .cmd_out(cmd));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic mr(input logic [2:0] ba, input logic [15:0] a);
      u_dpr_ctrl_model.mrs(ba, a, nop_c);
      #1;
   endtask
   // Beats alternate b0, b1; burst ends with the strobe low
   task automatic rb(input logic [15:0] a, input dpr_cmd_t f, input int lat,
         input int n, input logic [15:0] b0, input logic [15:0] b1);
      u_dpr_ctrl_model.rd(a, f);
      repeat (lat - 1) @(posedge mclk);
      for (int i = 0; i < n; i++) begin
         #1;
         chk(oe, 16'h1);
         chk(dq, i[0] ? b1 : b0);
         @(posedge mclk);
      end
      #1;
      chk(oe, 16'h0);
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      chk(oe, 16'h0);
      chk(dll, 16'h0);
      chk(pat, 16'h0);
      chk(lat_ok, 16'h1);
      rb(16'h0, nop_c, 8, 8, arr, arr);
      mr(DPR_MR_DLL, 16'h0001);
      chk(dll, 16'h1);
      chk(lat_ok, 16'h1);
      mr(DPR_MR_BURST, 16'h0071);
      chk(lat_ok, 16'h0);
      mr(DPR_MR_BURST, 16'h0061);
      mr(DPR_MR_PATTERN, 16'h0004);
      chk(pat, 16'h1);
      rb(16'h1000, nop_c, 7, 8, 16'h0, 16'hffff);
      mr(DPR_MR_PATTERN, 16'h0);
      mr(DPR_MR_DLL, 16'h0);
      chk(dll, 16'h0);
      mr(DPR_MR_PATTERN, 16'h0004);
      for (int c = 1; c >= 0; c--) begin
         @(posedge mclk);
         copy <= c[0];
         rb(16'h1ff8, dsel_c, 8, 8, 16'h0,
            c[0] ? 16'hffff : 16'h0101);
      end
      rb(16'h0000, nop_c, 8, 4, 16'h0, 16'h0101);
      rb(16'h0004, nop_c, 8, 4, 16'h0, 16'h0101);
      mr(DPR_MR_PATTERN, 16'h0);
      mr(DPR_MR_BURST, 16'h0062);
      mr(DPR_MR_PATTERN, 16'h0004);
      rb(16'h1004, nop_c, 8, 4, 16'h0, 16'h0101);
      mr(DPR_MR_PATTERN, 16'h0);
      chk(pat, 16'h0);
      rb(16'h0, nop_c, 8, 4, arr, arr);
      print_verdict();
   end
   // Whole run is some 150 cycles
   initial begin
      repeat (2000) @(posedge mclk);
      fails++;
      print_verdict();
   end
   task automatic print_verdict();
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
endmodule // ddr3_pattern_readout_dll_off_tb_top
`default_nettype wire
